// *** logic/ahl_consts.svh ***
// Functional notes
// - keep ten newest alarms, drop oldest
// - entry stamped with accumulated 100 ms time
// - index one is newest, older higher
// - repeat of the newest alarm within one hour skipped
// - reset and power loss keep history
// - clear request empties every history slot
// - warnings never enter the history
// - entry holds alarm code and name
// - servo-on deviation warning above level times percent
// - restart warning after power-up parameter change
// - motion warning when target outside soft limits
// - reset input pin selected by parameter field
// - warnings clear when condition goes away
// - overload warning precedes overload alarm
// - detect-select disables every warning
`ifndef AHL_CONSTS_SVH
`define AHL_CONSTS_SVH

// clock and timing
`define AHL_CLK_HZ        20000000
`define AHL_STEP_MS       100
`define AHL_HOUR_S        3600
`define AHL_PCT_DIV       100

// history geometry
`define AHL_HIST_DEPTH    10
`define AHL_TIME_W        32

// register byte addresses
`define AHL_REG_CTRL      8'h00
`define AHL_REG_STATUS    8'h04
`define AHL_REG_IRQ_STAT  8'h08
`define AHL_REG_IRQ_MASK  8'h0c
`define AHL_REG_DEV_LVL   8'h10
`define AHL_REG_WARN_PCT  8'h14
`define AHL_REG_FWD_LIM   8'h18
`define AHL_REG_REV_LIM   8'h1c
`define AHL_REG_BOOT_PAR  8'h20
`define AHL_REG_OPTIME    8'h24
`define AHL_REG_HIST_SEL  8'h28
`define AHL_REG_HIST_ID   8'h2c
`define AHL_REG_HIST_TIME 8'h30
`define AHL_REG_OVL_WARN  8'h34
`define AHL_REG_OVL_ALARM 8'h38

// control register fields
`define AHL_CTRL_NOWARN   0
`define AHL_CTRL_CLEAR    1
`define AHL_CTRL_PIN_LO   4
`define AHL_CTRL_PIN_HI   6

// status register fields
`define AHL_ST_FAULT      0
`define AHL_ST_WARN_LO    1
`define AHL_ST_WARN_HI    4
`define AHL_ST_RESTART    5
`define AHL_ST_CNT_LO     8
`define AHL_ST_CNT_HI     11

// interrupt event bits
`define AHL_IRQ_STORED    0
`define AHL_IRQ_WARN      1
`define AHL_IRQ_FAULT_CLR 2
`define AHL_IRQ_W         3

// history id word fields
`define AHL_ID_NAME_LO    16
`define AHL_ID_NAME_HI    23
`define AHL_ID_VALID      31

// reset values
`define AHL_RST_PIN       3'h0
`define AHL_RST_PCT       8'h64
`define AHL_RST_DEV_LVL   32'h0000ffff
`define AHL_RST_FWD_LIM   32'h7fffffff
`define AHL_RST_REV_LIM   32'h80000000
`define AHL_RST_OVL_WARN  16'h0c00
`define AHL_RST_OVL_ALARM 16'h1000
`define AHL_RST_SEL       4'h1

`endif

// *** logic/ahl_pkg.sv ***
package ahl_pkg;
  typedef logic [31:0] ahl_word_t;      // bus data word
  typedef logic [15:0] ahl_code_t;      // alarm code
  typedef logic [7:0]  ahl_name_t;      // alarm name index
  typedef logic [3:0]  ahl_cnt_t;       // history fill level / index
  // warning vector bit positions
  typedef enum logic [1:0] {
    AHL_W_DEV     = 2'b00,
    AHL_W_OVL     = 2'b01,
    AHL_W_RESTART = 2'b10,
    AHL_W_MOTION  = 2'b11
  } ahl_warn_t;
endpackage : ahl_pkg

// *** logic/ahl_logger.sv ***
`timescale 1ns/100ps
`include "ahl_consts.svh"

module ahl_logger #(
  parameter int          DEPTH      = `AHL_HIST_DEPTH,                    // history slots
  parameter int          TW         = `AHL_TIME_W,                        // time stamp width
  parameter int unsigned STEP_CYC   = `AHL_CLK_HZ / 1000 * `AHL_STEP_MS,  // cycles per 100 ms
  parameter int unsigned HOUR_STEPS = `AHL_HOUR_S * 1000 / `AHL_STEP_MS   // steps in one hour
) (
  input  wire logic                 clk_i,               // system clock
  input  wire logic                 rst_i,               // synchronous reset
  // wishbone slave
  input  wire logic                 wb_cyc_i,            // cycle
  input  wire logic                 wb_stb_i,            // strobe
  input  wire logic                 wb_we_i,             // write enable
  input  wire logic [7:0]           wb_adr_i,            // byte address
  input  wire logic [3:0]           wb_sel_i,            // byte lanes
  input  wire ahl_pkg::ahl_word_t   wb_dat_i,            // write data
  output logic      [31:0]          wb_dat_o,            // read data
  output logic                      wb_ack_o,            // acknowledge
  // power state
  input  wire logic                 control_power_on_i,  // control supply up
  input  wire logic                 main_power_on_i,     // main circuit up
  // alarm source
  input  wire logic                 alarm_event_i,       // one-cycle alarm pulse
  input  wire ahl_pkg::ahl_code_t   alarm_code_i,        // alarm code
  input  wire ahl_pkg::ahl_name_t   alarm_name_i,        // alarm name index
  // warning sources
  input  wire logic                 servo_on_i,          // servo-on state
  input  wire logic [31:0]          pos_deviation_i,     // position deviation magnitude
  input  wire logic [15:0]          load_level_i,        // overload integrator level
  input  wire logic                 target_valid_i,      // target position present
  input  wire logic signed [31:0]   target_pos_i,        // commanded target
  // connector input pins, active low
  input  wire logic [7:0]           input_pins_n_i,      // connector inputs
  // outputs
  output logic                      fault_output_o,      // latched alarm
  output logic                      overload_alarm_o,    // overload trip
  output logic [3:0]                warnings_o,          // warning vector
  output logic                      motion_error_warning_o, // soft limit warning
  output logic                      irq_o                // level interrupt
);

  // registers
  logic                  nowarn_q;         // warning detection disabled
  logic [2:0]            pin_sel_q;        // reset_pin_allocation
  logic [31:0]           dev_lvl_q;        // deviation_alarm_level_on
  logic [7:0]            pct_q;            // servo_on_warning_percent
  logic signed [31:0]    fwd_lim_q;        // forward_soft_limit
  logic signed [31:0]    rev_lim_q;        // reverse_soft_limit
  logic [31:0]           boot_par_q;       // power-up-only parameter
  logic [15:0]           ovl_warn_q;       // overload warning level
  logic [15:0]           ovl_alarm_q;      // overload alarm level
  logic [3:0]            hist_sel_q;       // history read index
  logic [`AHL_IRQ_W-1:0] irq_stat_q;       // sticky events
  logic [`AHL_IRQ_W-1:0] irq_mask_q;       // event enables
  logic                  restart_q;        // restart pending
  logic                  clr_req_q;        // history clear pulse
  logic [31:0]           step_cnt_q;       // cycles within step
  logic [TW-1:0]         optime_q;         // accumulated steps
  logic                  pin_q;            // delayed clear input
  logic [3:0]            warn_q;           // warnings, previous
  ahl_pkg::ahl_cnt_t     fill_q;           // valid entries

  // nonvolatile history store
  ahl_pkg::ahl_code_t    h_code_q [DEPTH]; // alarm codes
  ahl_pkg::ahl_name_t    h_name_q [DEPTH]; // alarm names
  logic [TW-1:0]         h_time_q [DEPTH]; // time stamps
  logic                  h_vld_q  [DEPTH]; // slot used

  // bus decode
  logic          bus_req;      // request this cycle
  logic          bus_wr;       // write taken
  logic [31:0]   wmask;        // byte lane mask

  // byte lane mask from sel
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // masked update of a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  assign wmask   = lane_mask(wb_sel_i);

  // warning detection
  logic          clear_in_n;   // alarm_clear_input, active low
  logic          clr_edge;     // asserting edge
  logic [39:0]   dev_scaled;   // deviation times 100
  logic [39:0]   dev_limit;    // level times percent
  logic          w_dev;        // deviation condition
  logic          w_ovl;        // overload condition
  logic          w_mot;        // soft limit condition
  logic [3:0]    warn_d;       // gated warnings
  logic          ovl_trip;     // overload alarm condition

  assign clear_in_n = input_pins_n_i[pin_sel_q];
  assign clr_edge   = pin_q & ~clear_in_n;

  assign dev_scaled = {8'h00, pos_deviation_i} * 40'(`AHL_PCT_DIV);
  assign dev_limit  = {8'h00, dev_lvl_q} * {32'h0, pct_q};
  assign w_dev      = servo_on_i & (dev_scaled > dev_limit);
  assign ovl_trip   = load_level_i >= ovl_alarm_q;
  assign w_ovl      = (load_level_i >= ovl_warn_q) | ovl_trip;
  assign w_mot      = target_valid_i & ((target_pos_i > fwd_lim_q) |
                                        (target_pos_i < rev_lim_q));

  // live conditions only, so each warning drops with its cause
  always_comb begin
    warn_d                         = 4'h0;
    warn_d[ahl_pkg::AHL_W_DEV]     = w_dev;
    warn_d[ahl_pkg::AHL_W_OVL]     = w_ovl;
    warn_d[ahl_pkg::AHL_W_RESTART] = restart_q;
    warn_d[ahl_pkg::AHL_W_MOTION]  = w_mot;
    if (nowarn_q) begin
      warn_d = 4'h0;
    end
  end

  // history store decision
  logic          newest_same;  // repeat of newest entry
  logic [TW-1:0] since;        // steps since newest
  logic          store;        // write a new entry

  assign newest_same = h_vld_q[0] & (h_code_q[0] == alarm_code_i);
  assign since       = optime_q - h_time_q[0];
  // warnings have no path here, only alarm events
  assign store       = alarm_event_i & ~(newest_same & (since < TW'(HOUR_STEPS)));

  // processes
  // bus acknowledge, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read mux, registered with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (bus_req & ~wb_we_i) begin
      unique case (wb_adr_i)
        `AHL_REG_CTRL:      wb_dat_o <= {25'h0, pin_sel_q, 3'h0, nowarn_q};
        `AHL_REG_STATUS:    wb_dat_o <= {20'h0, fill_q, 2'h0, restart_q, warn_q, fault_output_o};
        `AHL_REG_IRQ_STAT:  wb_dat_o <= {29'h0, irq_stat_q};
        `AHL_REG_IRQ_MASK:  wb_dat_o <= {29'h0, irq_mask_q};
        `AHL_REG_DEV_LVL:   wb_dat_o <= dev_lvl_q;
        `AHL_REG_WARN_PCT:  wb_dat_o <= {24'h0, pct_q};
        `AHL_REG_FWD_LIM:   wb_dat_o <= fwd_lim_q;
        `AHL_REG_REV_LIM:   wb_dat_o <= rev_lim_q;
        `AHL_REG_BOOT_PAR:  wb_dat_o <= boot_par_q;
        `AHL_REG_OPTIME:    wb_dat_o <= 32'(optime_q);
        `AHL_REG_HIST_SEL:  wb_dat_o <= {28'h0, hist_sel_q};
        `AHL_REG_HIST_ID: begin
          // index one is the newest slot; out of range reads zero
          if (hist_sel_q != 4'h0 && 32'(hist_sel_q) <= DEPTH && h_vld_q[hist_sel_q - 4'h1]) begin
            wb_dat_o <= {1'b1, 7'h0, h_name_q[hist_sel_q - 4'h1], h_code_q[hist_sel_q - 4'h1]};
          end else begin
            wb_dat_o <= 32'h0;
          end
        end
        `AHL_REG_HIST_TIME: begin
          if (hist_sel_q != 4'h0 && 32'(hist_sel_q) <= DEPTH && h_vld_q[hist_sel_q - 4'h1]) begin
            wb_dat_o <= 32'(h_time_q[hist_sel_q - 4'h1]);
          end else begin
            wb_dat_o <= 32'h0;
          end
        end
        `AHL_REG_OVL_WARN:  wb_dat_o <= {16'h0, ovl_warn_q};
        `AHL_REG_OVL_ALARM: wb_dat_o <= {16'h0, ovl_alarm_q};
        default:            wb_dat_o <= 32'h0;   // unmapped reads zero
      endcase
    end
  end

  // configuration registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nowarn_q    <= 1'b0;
      pin_sel_q   <= `AHL_RST_PIN;
      dev_lvl_q   <= `AHL_RST_DEV_LVL;
      pct_q       <= `AHL_RST_PCT;
      fwd_lim_q   <= `AHL_RST_FWD_LIM;
      rev_lim_q   <= `AHL_RST_REV_LIM;
      boot_par_q  <= 32'h0;
      ovl_warn_q  <= `AHL_RST_OVL_WARN;
      ovl_alarm_q <= `AHL_RST_OVL_ALARM;
      hist_sel_q  <= `AHL_RST_SEL;
      irq_mask_q  <= '0;
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        `AHL_REG_CTRL: begin
          if (wb_sel_i[0]) begin
            nowarn_q  <= wb_dat_i[`AHL_CTRL_NOWARN];
            pin_sel_q <= wb_dat_i[`AHL_CTRL_PIN_HI:`AHL_CTRL_PIN_LO];
          end
        end
        `AHL_REG_IRQ_MASK:  if (wb_sel_i[0]) irq_mask_q <= wb_dat_i[`AHL_IRQ_W-1:0];
        `AHL_REG_DEV_LVL:   dev_lvl_q   <= merge(dev_lvl_q, wb_dat_i, wmask);
        `AHL_REG_WARN_PCT:  if (wb_sel_i[0]) pct_q <= wb_dat_i[7:0];
        `AHL_REG_FWD_LIM:   fwd_lim_q   <= merge(fwd_lim_q, wb_dat_i, wmask);
        `AHL_REG_REV_LIM:   rev_lim_q   <= merge(rev_lim_q, wb_dat_i, wmask);
        `AHL_REG_BOOT_PAR:  boot_par_q  <= merge(boot_par_q, wb_dat_i, wmask);
        `AHL_REG_HIST_SEL:  if (wb_sel_i[0]) hist_sel_q <= wb_dat_i[3:0];
        `AHL_REG_OVL_WARN:  ovl_warn_q  <= 16'(merge({16'h0, ovl_warn_q}, wb_dat_i, wmask));
        `AHL_REG_OVL_ALARM: ovl_alarm_q <= 16'(merge({16'h0, ovl_alarm_q}, wb_dat_i, wmask));
        default: ;                               // read-only or unmapped
      endcase
    end
  end

  // history clear pulse from the control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_req_q <= 1'b0;
    end else begin
      clr_req_q <= bus_wr & (wb_adr_i == `AHL_REG_CTRL) & wb_sel_i[0] & wb_dat_i[`AHL_CTRL_CLEAR];
    end
  end

  // restart warning: held until the next power-up reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_q <= 1'b0;
    end else if (bus_wr & (wb_adr_i == `AHL_REG_BOOT_PAR) & (|wb_sel_i)) begin
      restart_q <= 1'b1;
    end
  end

  // operation time, counts only while both supplies are up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt_q <= 32'h0;
      optime_q   <= '0;
    end else if (control_power_on_i & main_power_on_i) begin
      if (step_cnt_q == STEP_CYC - 1) begin
        step_cnt_q <= 32'h0;
        optime_q   <= optime_q + TW'(1);
      end else begin
        step_cnt_q <= step_cnt_q + 32'h1;
      end
    end
  end

  // history shift store, deliberately outside the reset
  always_ff @(posedge clk_i) begin
    if (clr_req_q) begin
      for (int i = 0; i < DEPTH; i++) begin
        h_vld_q[i]  <= 1'b0;
        h_code_q[i] <= '0;
        h_name_q[i] <= '0;
        h_time_q[i] <= '0;
      end
    end else if (store) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        h_vld_q[i]  <= h_vld_q[i-1];
        h_code_q[i] <= h_code_q[i-1];
        h_name_q[i] <= h_name_q[i-1];
        h_time_q[i] <= h_time_q[i-1];
      end
      h_vld_q[0]  <= 1'b1;
      h_code_q[0] <= alarm_code_i;
      h_name_q[0] <= alarm_name_i;
      h_time_q[0] <= optime_q;
    end
  end

  // fill level, kept with the store through reset
  always_ff @(posedge clk_i) begin
    if (clr_req_q) begin
      fill_q <= 4'h0;
    end else if (store && 32'(fill_q) < DEPTH) begin
      fill_q <= fill_q + 4'h1;
    end
  end

  // alarm latch and clear input edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q          <= 1'b1;
      fault_output_o <= 1'b0;
    end else begin
      pin_q <= clear_in_n;
      if (alarm_event_i | ovl_trip) begin
        fault_output_o <= 1'b1;                  // new alarm beats clear
      end else if (clr_edge) begin
        fault_output_o <= 1'b0;
      end
    end
  end

  // warning and trip outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_q                 <= 4'h0;
      motion_error_warning_o <= 1'b0;
      overload_alarm_o       <= 1'b0;
    end else begin
      warn_q                 <= warn_d;
      motion_error_warning_o <= warn_d[ahl_pkg::AHL_W_MOTION];
      overload_alarm_o       <= ovl_trip;
    end
  end

  assign warnings_o = warn_q;

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      logic [`AHL_IRQ_W-1:0] ev;
      logic [`AHL_IRQ_W-1:0] clr;
      ev                     = '0;
      ev[`AHL_IRQ_STORED]    = store;
      ev[`AHL_IRQ_WARN]      = |(warn_d & ~warn_q);
      ev[`AHL_IRQ_FAULT_CLR] = clr_edge & fault_output_o & ~alarm_event_i & ~ovl_trip;
      clr = '0;
      if (bus_wr && wb_adr_i == `AHL_REG_IRQ_STAT && wb_sel_i[0]) begin
        clr = wb_dat_i[`AHL_IRQ_W-1:0];
      end
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
    end
  end

  // interrupt level output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule : ahl_logger

// *** tb/ahl_checker.sv ***
`timescale 1ns/100ps
module ahl_checker (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire ahl_pkg::ahl_word_t wb_dat_i,
  input wire logic               wb_ack_o,
  input wire logic               alarm_event_i,
  input wire logic [7:0]         input_pins_n_i,
  input wire logic               fault_output_o,
  input wire logic               overload_alarm_o,
  input wire logic [3:0]         warnings_o,
  input wire logic               motion_error_warning_o
);
  logic       nowarn_q;   // shadow of the no-warnings bit
  logic [2:0] pin_sel_q;  // shadow of the clear pin select
  wire        ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0];
  wire        clr_pin = input_pins_n_i[pin_sel_q];  // level of the selected clear input

  // shadow the control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nowarn_q  <= 1'b0;
      pin_sel_q <= 3'h0;
    end else if (ctrl_wr) begin
      nowarn_q  <= wb_dat_i[0];
      pin_sel_q <= wb_dat_i[6:4];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // clear press with no alarm cause at that edge
  sequence s_pin_fall; $fell(clr_pin); endsequence
  sequence s_calm; !alarm_event_i ##1 !overload_alarm_o; endsequence

  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_fault_set; alarm_event_i |=> fault_output_o; endproperty
  property p_fault_keep; $fell(fault_output_o) |-> !$past(alarm_event_i); endproperty
  property p_pin_clear; s_pin_fall ##0 s_calm |-> !fault_output_o; endproperty
  property p_mirror; motion_error_warning_o == warnings_o[3]; endproperty
  property p_quiet; nowarn_q && $past(nowarn_q) |-> warnings_o == 4'h0; endproperty
  property p_ovl_first; overload_alarm_o && !nowarn_q && !$past(nowarn_q) |-> warnings_o[1]; endproperty

  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_fault_set: assert property (p_fault_set) else $error("alarm did not latch fault");
  a_fault_keep: assert property (p_fault_keep) else $error("fault dropped on alarm");
  a_pin_clear: assert property (p_pin_clear) else $error("clear input ignored");
  a_mirror: assert property (p_mirror) else $error("motion warning outputs differ");
  a_quiet: assert property (p_quiet) else $error("warning while detection off");
  a_ovl_first: assert property (p_ovl_first) else $error("trip without warning");
endmodule : ahl_checker

bind ahl_logger ahl_checker i_chk (.*);

// *** tb/ahl_host_model.sv ***
`timescale 1ns/100ps
module ahl_host_model (
  input  wire logic       clk_i,      // system clock
  input  wire logic [2:0] pin_sel_i,  // clear input pin
  input  wire logic       fire_i,     // request one clear press
  input  wire logic       cause_i,    // alarm cause still present
  input  wire logic [7:0] hold_i,     // press length, cycles
  output logic      [7:0] pins_n_o    // connector inputs, idle high
);
  logic [7:0] left_q = 8'h00;  // cycles of the press still to run
  initial pins_n_o = 8'hff;

  // hold the selected input low, then release it
  always @(posedge clk_i) begin
    if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
      if (left_q == 8'h01) pins_n_o <= 8'hff;
    end else if (fire_i && !cause_i) begin
      pins_n_o <= ~(8'h01 << pin_sel_i);
      left_q   <= hold_i;
    end
  end
endmodule : ahl_host_model

// *** tb/test_alarm_history_and_warning_logger.sv ***
`timescale 1ns/100ps
module test_alarm_history_and_warning_logger;
  logic               clk_i, rst_i, cyc, stb, we, ack;   // clock, reset, bus
  logic [7:0]         adr, pins, hold;                   // bus address, inputs, press length
  ahl_pkg::ahl_word_t wdat, rdat, rd;                    // bus data and last read
  logic               cpw, mpw, aev, srv, tv, fire;      // stimulus levels
  logic               fault, ovl, mot, irq;              // design flags
  ahl_pkg::ahl_code_t acode;                             // alarm code
  ahl_pkg::ahl_name_t aname;                             // alarm name
  logic [31:0]        dev;                               // deviation
  logic [15:0]        ld;                                // load level
  logic signed [31:0] tgt;                               // target position
  logic [3:0]         warn;                              // warning vector
  logic [2:0]         pin_sel;                           // clear pin in use
  int                 errors, n_compared, cycles, c, ps; // counters and scratch
  int                 qi[$], qt[$];                      // model history, newest first
  int                 opt, lvl, pct, fwd, rev;           // model time and thresholds
  bit                 nw, rpend;                         // model no-warnings and restart
  logic [7:0]         ra[10] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h28, 8'h34, 8'h38, 8'h24};
  logic [31:0]        rv[10] = '{0, 0, 32'hffff, 32'h64, 32'h7fffffff, 32'h80000000, 1, 32'hc00, 32'h1000, 0};

  ahl_logger #(.STEP_CYC(4), .HOUR_STEPS(5)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .control_power_on_i(cpw), .main_power_on_i(mpw), .alarm_event_i(aev), .alarm_code_i(acode),
    .alarm_name_i(aname), .servo_on_i(srv), .pos_deviation_i(dev), .load_level_i(ld), .target_valid_i(tv),
    .target_pos_i(tgt), .input_pins_n_i(pins), .fault_output_o(fault), .overload_alarm_o(ovl),
    .warnings_o(warn), .motion_error_warning_o(mot), .irq_o(irq));
  ahl_host_model i_host (.clk_i(clk_i), .pin_sel_i(pin_sel), .fire_i(fire), .cause_i(aev || ld >= 16'h1000),
    .hold_i(hold), .pins_n_o(pins));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one classic bus cycle; read data lands in rd
  task automatic wb(input logic w, input logic [7:0] a, input ahl_pkg::ahl_word_t d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // fill level and every slot against the model
  task automatic fill_chk();
    wb(0, 8'h04, 0);
    chk("fill", rd[11:8], qi.size());
    for (int i = 1; i <= 11; i++) begin
      wb(1, 8'h28, i);
      wb(0, 8'h2c, 0);
      chk("id", rd, i <= qi.size() ? 32'h80000000 | qi[i-1] : 0);
      wb(0, 8'h30, 0);
      chk("stamp", rd, i <= qi.size() ? qt[i-1] : 0);
    end
  endtask : fill_chk

  // one alarm pulse and its model update
  task automatic alarm(input int code, input int name);
    @(posedge clk_i);
    aev   <= 1'b1;
    acode <= code[15:0];
    aname <= name[7:0];
    @(posedge clk_i);
    aev <= 1'b0;
    if (!(qi.size() > 0 && qi[0][15:0] == code[15:0] && opt - qt[0] < 5)) begin
      qi.push_front({name[7:0], code[15:0]});
      qt.push_front(opt);
      if (qi.size() > 10) qi.pop_back();
      if (qt.size() > 10) qt.pop_back();
    end
    @(negedge clk_i);
    chk("fault", fault, 1);
  endtask : alarm

  // run n time steps, main supply as given
  task automatic adv(input int n, input bit m);
    @(posedge clk_i);
    cpw <= 1'b1;
    mpw <= m;
    repeat (4 * n) @(posedge clk_i);
    cpw <= 1'b0;
    mpw <= 1'b0;
    if (m) opt += n;
  endtask : adv

  // host presses the clear input, prompt or slow
  task automatic clear_pin();
    @(posedge clk_i);
    fire <= 1'b1;
    hold <= 8'(1 + $urandom % 4);
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk("fault clear", fault, 0);
  endtask : clear_pin

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i   <= 1'b0;
    pin_sel <= 3'h0;
    opt   = 0;
    rpend = 0;
    nw    = 0;
  endtask : do_reset

  // expected warning vector from the thresholds
  function automatic logic [3:0] wexp();
    logic [3:0] w;
    w[0] = srv && dev * 100 > lvl * pct;
    w[1] = ld >= 16'h0c00;
    w[2] = rpend;
    w[3] = tv && (tgt > fwd || tgt < rev);
    return nw ? 4'h0 : w;
  endfunction : wexp

  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask : endt

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    {rst_i, cyc, stb, we, adr, wdat, cpw, mpw, aev, acode, aname} = '0;
    {srv, dev, ld, tv, tgt, fire, pin_sel, errors, n_compared, cycles} = '0;
    hold = 8'h01;
    void'($urandom(86605));
    do_reset();
    // reset values, unmapped and read-only places
    foreach (ra[i]) begin
      wb(0, ra[i], 0);
      chk("reset value", rd, rv[i]);
    end
    wb(1, 8'h3c, 32'hffffffff);
    wb(0, 8'h3c, 0);
    chk("unmapped", rd, 0);
    wb(1, 8'h24, 32'h5);
    wb(0, 8'h24, 0);
    chk("time read only", rd, 0);
    wb(1, 8'h00, 32'h2);
    fill_chk();
    endt("defaults");
    // time runs only with both supplies
    adv(3, 1);
    adv(2, 0);
    wb(0, 8'h24, 0);
    chk("time", rd, opt);
    // overflow past ten entries, event unmasked
    wb(1, 8'h0c, 1);
    for (int i = 0; i < 12; i++) begin
      alarm($urandom, $urandom);
      adv(1, 1);
    end
    chk("irq", irq, 1);
    wb(1, 8'h08, 7);
    wb(1, 8'h0c, 0);
    chk("irq cleared", irq, 0);
    fill_chk();
    endt("history");
    // same code: dropped soon, kept after the hour
    c = qi[0] & 32'hffff;
    alarm(c, 7);
    adv(4, 1);
    alarm(c, 9);
    fill_chk();
    wb(0, 8'h08, 0);
    chk("masked event", {irq, rd[0]}, 2'b01);
    endt("repeat");
    // clear by a chosen pin; reset keeps history
    ps = $urandom % 8;
    wb(1, 8'h00, ps << 4);
    pin_sel <= 3'(ps);
    clear_pin();
    do_reset();
    fill_chk();
    endt("clear input");
    // random inputs near each threshold
    wb(1, 8'h10, 1000);
    wb(1, 8'h14, 50);
    wb(1, 8'h18, 100);
    wb(1, 8'h1c, -100);
    {lvl, pct, fwd, rev} = {32'd1000, 32'd50, 32'd100, -32'sd100};
    for (int i = 0; i < 16; i++) begin
      if (i == 8) wb(1, 8'h20, 1);
      rpend = i >= 8;
      @(posedge clk_i);
      srv <= $urandom % 2;
      dev <= 495 + $urandom % 10;
      ld  <= 16'h0bfe + 16'($urandom % 4);
      tv  <= $urandom % 2;
      tgt <= -102 + int'($urandom % 205);
      repeat (3) @(negedge clk_i);
      chk("warnings", warn, wexp());
    end
    wb(1, 8'h00, 1);
    nw = 1;
    repeat (3) @(negedge clk_i);
    chk("warnings off", warn, wexp());
    wb(1, 8'h00, 0);
    nw = 0;
    fill_chk();
    @(posedge clk_i);
    ld <= 16'h1000;
    repeat (3) @(negedge clk_i);
    chk("overload", {ovl, warn[1]}, 2'b11);
    @(posedge clk_i);
    ld <= 16'h0000;
    clear_pin();
    do_reset();
    chk("restart gone", warn, 0);
    endt("warnings");
    // explicit clear empties every slot
    wb(1, 8'h00, 32'h2);
    qi.delete();
    qt.delete();
    fill_chk();
    endt("history clear");
    report_and_stop();
  end
endmodule : test_alarm_history_and_warning_logger
